//--- include/gpo_pkg.sv
package gpo_pkg;

  // bus word and pin counts
  localparam int unsigned GPO_DATA_W     = 32;
  localparam int unsigned GPO_ADDR_W     = 32;
  localparam int unsigned GPO_GROUPS     = 5;
  localparam int unsigned GPO_BANK_PINS  = 16;
  localparam int unsigned GPO_PINS       = 144;
  localparam int unsigned GPO_DEC_W      = 12;

  typedef logic [GPO_DATA_W-1:0] gpo_word_t;
  typedef logic [GPO_ADDR_W-1:0] gpo_addr_t;
  typedef logic [GPO_PINS-1:0]   gpo_pins_t;
  typedef logic [GPO_DEC_W-1:0]  gpo_off_t;

  // register map: each bank group holds direction, level, set and clear words
  localparam gpo_off_t GPO_GROUP_BASE   = 12'h010;
  localparam gpo_off_t GPO_GROUP_STRIDE = 12'h028;
  localparam gpo_off_t GPO_OFF_DIR      = 12'h000;
  localparam gpo_off_t GPO_OFF_LEVEL    = 12'h004;
  localparam gpo_off_t GPO_OFF_SET      = 12'h008;
  localparam gpo_off_t GPO_OFF_CLR      = 12'h00C;

  // implemented bits: the last group holds a single bank in its low half
  localparam gpo_word_t GPO_MASK_PAIR   = 32'hFFFFFFFF;
  localparam gpo_word_t GPO_MASK_SINGLE = 32'h0000FFFF;

  // reset values: pins come up as inputs, levels low
  localparam gpo_word_t GPO_RST_LEVEL   = 32'h00000000;
  localparam gpo_word_t GPO_RST_RDATA   = 32'h00000000;

  // ahb transfer type bit that marks an active transfer
  localparam int unsigned GPO_HTRANS_ACTIVE_BIT = 1;

  // register view within a group
  typedef enum logic [1:0] {
    GPO_VIEW_DIR,
    GPO_VIEW_LEVEL,
    GPO_VIEW_SET,
    GPO_VIEW_CLR
  } gpo_view_t;

  // bus phase of the slave
  typedef enum logic [1:0] {
    GPO_PH_IDLE,
    GPO_PH_WRITE,
    GPO_PH_READ_WAIT,
    GPO_PH_READ_DONE
  } gpo_phase_t;

  // captured address phase
  typedef struct packed {
    logic       hit;
    logic [2:0] group;
    gpo_view_t  view;
  } gpo_req_t;

endpackage

//--- rtl/gpo_output_drive.sv
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
// Function
// - each pin keeps one stored level bit: 0 drives low, 1 drives high
// - stored level reaches the pin only while its direction bit is 0
// - a pin set as input is never influenced by its stored level
// - level view read returns stored bits, never the pin state
// - level view write loads every implemented bit straight from the word
// - level, set and clear views read 0 after reset
// - set view: 1 forces stored level high, 0 leaves it
// - set view read returns the current stored levels
// - clear view: 1 forces stored level low, 0 leaves it
// - clear view read returns the current stored levels
// - set or clear writes never move a pin configured as input
// - paired words: lower bank in bits 15..0, higher bank in 31..16
// - single-bank word: bits 31..16 reserved, read 0, writes ignored
// - direction bit 0 selects output, 1 input; all pins inputs after reset
module gpo_output_drive (
  input  wire logic               MCLK,
  input  wire logic               RST,
  input  wire logic               HSEL,
  input  wire gpo_pkg::gpo_addr_t HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire gpo_pkg::gpo_word_t HWDATA,
  input  wire logic               HREADY,
  output gpo_pkg::gpo_word_t      HRDATA,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  output gpo_pkg::gpo_pins_t      PIN_OUT,
  output gpo_pkg::gpo_pins_t      PIN_OE
);
  import gpo_pkg::*;

  // bus side state
  gpo_phase_t phase;
  gpo_req_t   req;
  gpo_req_t   next_req;
  logic       addr_take;
  gpo_word_t  next_rdata;
  gpo_off_t   offset;
  gpo_off_t   rel;

  // per group stores and their next values
  gpo_word_t  level      [GPO_GROUPS];
  gpo_word_t  dir        [GPO_GROUPS];
  gpo_word_t  next_level [GPO_GROUPS];
  gpo_word_t  next_dir   [GPO_GROUPS];

  // next values laid out one bit per pin
  gpo_pins_t  next_level_pins;
  gpo_pins_t  next_dir_pins;

  // register words by name, as software sees them
  gpo_word_t  pin_direction_bits_0_1;
  gpo_word_t  pin_direction_bits_2_3;
  gpo_word_t  pin_direction_bits_4_5;
  gpo_word_t  pin_direction_bits_6_7;
  gpo_word_t  pin_direction_bits_8;
  gpo_word_t  out_level_banks_0_1;
  gpo_word_t  out_level_banks_2_3;
  gpo_word_t  out_level_banks_4_5;
  gpo_word_t  out_level_banks_6_7;
  gpo_word_t  out_level_bank_8;
  gpo_word_t  drive_high_banks_0_1;
  gpo_word_t  drive_high_banks_2_3;
  gpo_word_t  drive_high_banks_4_5;
  gpo_word_t  drive_high_banks_6_7;
  gpo_word_t  drive_high_bank_8;
  gpo_word_t  drive_low_banks_0_1;
  gpo_word_t  drive_low_banks_2_3;
  gpo_word_t  drive_low_banks_4_5;
  gpo_word_t  drive_low_banks_6_7;
  gpo_word_t  drive_low_bank_8;

  // address phase accepted only when the bus is ready and we are selected
  assign addr_take = HSEL && HREADY && HTRANS[GPO_HTRANS_ACTIVE_BIT];
  assign offset    = HADDR[GPO_DEC_W-1:0];

  // decode byte offset into group and view; misaligned or unmapped is a miss
  always_comb begin
    next_req = '{hit: 1'b0, group: 3'd0, view: GPO_VIEW_DIR};
    rel      = '0;
    for (int g = 0; g < GPO_GROUPS; g++) begin
      rel = offset - GPO_GROUP_BASE - gpo_off_t'(g) * GPO_GROUP_STRIDE;
      if (rel == GPO_OFF_DIR) begin
        next_req = '{hit: 1'b1, group: 3'(g), view: GPO_VIEW_DIR};
      end else if (rel == GPO_OFF_LEVEL) begin
        next_req = '{hit: 1'b1, group: 3'(g), view: GPO_VIEW_LEVEL};
      end else if (rel == GPO_OFF_SET) begin
        next_req = '{hit: 1'b1, group: 3'(g), view: GPO_VIEW_SET};
      end else if (rel == GPO_OFF_CLR) begin
        next_req = '{hit: 1'b1, group: 3'(g), view: GPO_VIEW_CLR};
      end
    end
  end

  // bus phase tracking; reads take one wait state so a prior write is visible
  always_ff @(posedge MCLK) begin
    if (RST) begin
      phase <= GPO_PH_IDLE;
    end else if (phase == GPO_PH_READ_WAIT) begin
      phase <= GPO_PH_READ_DONE;
    end else if (addr_take) begin
      phase <= HWRITE ? GPO_PH_WRITE : GPO_PH_READ_WAIT;
    end else begin
      phase <= GPO_PH_IDLE;
    end
  end

  // hold the decoded address for the data phase
  always_ff @(posedge MCLK) begin
    if (RST) begin
      req <= '{hit: 1'b0, group: 3'd0, view: GPO_VIEW_DIR};
    end else if (addr_take && phase != GPO_PH_READ_WAIT) begin
      req <= next_req;
    end
  end

  assign HREADYOUT = (phase != GPO_PH_READ_WAIT);
  assign HRESP     = 1'b0;

  // per group store, direction and write strobes
  generate
    for (genvar g = 0; g < GPO_GROUPS; g++) begin : g_group
      localparam gpo_word_t MASK = (g == GPO_GROUPS - 1) ? GPO_MASK_SINGLE
                                                         : GPO_MASK_PAIR;
      logic      wr_here;
      logic      wr_dir;
      logic      wr_level;
      logic      wr_set;
      logic      wr_clr;
      gpo_word_t wr_bits;

      // one write strobe per view of this group
      assign wr_here  = (phase == GPO_PH_WRITE) && req.hit && (req.group == 3'(g));
      assign wr_dir   = wr_here && (req.view == GPO_VIEW_DIR);
      assign wr_level = wr_here && (req.view == GPO_VIEW_LEVEL);
      assign wr_set   = wr_here && (req.view == GPO_VIEW_SET);
      assign wr_clr   = wr_here && (req.view == GPO_VIEW_CLR);
      assign wr_bits  = HWDATA & MASK;

      // shared level store behind all three views; one bus write per cycle
      always_comb begin
        next_level[g] = level[g];
        if (wr_level) begin
          next_level[g] = wr_bits;
        end else if (wr_set) begin
          next_level[g] = level[g] | wr_bits;
        end else if (wr_clr) begin
          next_level[g] = level[g] & ~wr_bits;
        end
      end

      // direction: 1 input, 0 output
      always_comb begin
        next_dir[g] = dir[g];
        if (wr_dir) begin
          next_dir[g] = wr_bits;
        end
      end

      // level store
      always_ff @(posedge MCLK) begin
        if (RST) begin
          level[g] <= GPO_RST_LEVEL;
        end else begin
          level[g] <= next_level[g];
        end
      end

      // direction store; every pin is an input out of reset
      always_ff @(posedge MCLK) begin
        if (RST) begin
          dir[g] <= MASK;
        end else begin
          dir[g] <= next_dir[g];
        end
      end
    end
  endgenerate

  // per pin: take the bit of the group word that holds this pin
  generate
    for (genvar p = 0; p < GPO_PINS; p++) begin : g_pin
      localparam int unsigned GRP = p / GPO_DATA_W;
      localparam int unsigned BIT = p % GPO_DATA_W;
      assign next_level_pins[p] = next_level[GRP][BIT];
      assign next_dir_pins[p]   = next_dir[GRP][BIT];
    end
  endgenerate

  // pin drive flops fed from the next values, so pins move on the write edge
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PIN_OE  <= '0;
      PIN_OUT <= '0;
    end else begin
      PIN_OE  <= ~next_dir_pins;
      PIN_OUT <= next_level_pins & ~next_dir_pins;
    end
  end

  // direction words
  assign pin_direction_bits_0_1 = dir[0];
  assign pin_direction_bits_2_3 = dir[1];
  assign pin_direction_bits_4_5 = dir[2];
  assign pin_direction_bits_6_7 = dir[3];
  assign pin_direction_bits_8   = dir[4];

  // level view words show the store, never the pins
  assign out_level_banks_0_1    = level[0];
  assign out_level_banks_2_3    = level[1];
  assign out_level_banks_4_5    = level[2];
  assign out_level_banks_6_7    = level[3];
  assign out_level_bank_8       = level[4];

  // set view words read back the current store
  assign drive_high_banks_0_1   = level[0];
  assign drive_high_banks_2_3   = level[1];
  assign drive_high_banks_4_5   = level[2];
  assign drive_high_banks_6_7   = level[3];
  assign drive_high_bank_8      = level[4];

  // clear view words read back the current store
  assign drive_low_banks_0_1    = level[0];
  assign drive_low_banks_2_3    = level[1];
  assign drive_low_banks_4_5    = level[2];
  assign drive_low_banks_6_7    = level[3];
  assign drive_low_bank_8       = level[4];

  // read data: level, set and clear views all show the stored levels
  always_comb begin
    next_rdata = GPO_RST_RDATA;
    if (req.hit) begin
      unique case (req.group)
        // banks 0 and 1
        3'h0: begin
          unique case (req.view)
            GPO_VIEW_DIR: begin
              next_rdata = pin_direction_bits_0_1;
            end
            GPO_VIEW_LEVEL: begin
              next_rdata = out_level_banks_0_1;
            end
            GPO_VIEW_SET: begin
              next_rdata = drive_high_banks_0_1;
            end
            GPO_VIEW_CLR: begin
              next_rdata = drive_low_banks_0_1;
            end
          endcase
        end

        // banks 2 and 3
        3'h1: begin
          unique case (req.view)
            GPO_VIEW_DIR: begin
              next_rdata = pin_direction_bits_2_3;
            end
            GPO_VIEW_LEVEL: begin
              next_rdata = out_level_banks_2_3;
            end
            GPO_VIEW_SET: begin
              next_rdata = drive_high_banks_2_3;
            end
            GPO_VIEW_CLR: begin
              next_rdata = drive_low_banks_2_3;
            end
          endcase
        end

        // banks 4 and 5
        3'h2: begin
          unique case (req.view)
            GPO_VIEW_DIR: begin
              next_rdata = pin_direction_bits_4_5;
            end
            GPO_VIEW_LEVEL: begin
              next_rdata = out_level_banks_4_5;
            end
            GPO_VIEW_SET: begin
              next_rdata = drive_high_banks_4_5;
            end
            GPO_VIEW_CLR: begin
              next_rdata = drive_low_banks_4_5;
            end
          endcase
        end

        // banks 6 and 7
        3'h3: begin
          unique case (req.view)
            GPO_VIEW_DIR: begin
              next_rdata = pin_direction_bits_6_7;
            end
            GPO_VIEW_LEVEL: begin
              next_rdata = out_level_banks_6_7;
            end
            GPO_VIEW_SET: begin
              next_rdata = drive_high_banks_6_7;
            end
            GPO_VIEW_CLR: begin
              next_rdata = drive_low_banks_6_7;
            end
          endcase
        end

        // bank 8 alone in its low half
        3'h4: begin
          unique case (req.view)
            GPO_VIEW_DIR: begin
              next_rdata = pin_direction_bits_8;
            end
            GPO_VIEW_LEVEL: begin
              next_rdata = out_level_bank_8;
            end
            GPO_VIEW_SET: begin
              next_rdata = drive_high_bank_8;
            end
            GPO_VIEW_CLR: begin
              next_rdata = drive_low_bank_8;
            end
          endcase
        end
        default: begin
          next_rdata = GPO_RST_RDATA;
        end
      endcase
    end
  end

  // read data register, loaded during the wait state
  always_ff @(posedge MCLK) begin
    if (RST) begin
      HRDATA <= GPO_RST_RDATA;
    end else if (phase == GPO_PH_READ_WAIT) begin
      HRDATA <= next_rdata;
    end
  end

endmodule // gpo_output_drive

//--- test/gpo_drive_asserts.sv
`timescale 1ns/100ps
module gpo_drive_asserts (
  input wire logic               MCLK,
  input wire logic               RST,
  input wire logic               HSEL,
  input wire gpo_pkg::gpo_addr_t HADDR,
  input wire logic [1:0]         HTRANS,
  input wire logic               HWRITE,
  input wire gpo_pkg::gpo_word_t HWDATA,
  input wire logic               HREADY,
  input wire gpo_pkg::gpo_word_t HRDATA,
  input wire logic               HREADYOUT,
  input wire gpo_pkg::gpo_pins_t PIN_OUT,
  input wire gpo_pkg::gpo_pins_t PIN_OE
);
  import gpo_pkg::*;
  logic take;
  logic rd_take;
  logic wr_d1;
  // accepted transfers and a one-cycle echo of writes
  assign take = HSEL && HREADY && HTRANS[1];
  assign rd_take = take && !HWRITE;
  always_ff @(posedge MCLK) begin
    wr_d1 <= RST ? 1'b0 : (take && HWRITE);
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence lvl0_wr;
    take && HWRITE && HADDR[11:0] == GPO_GROUP_BASE + GPO_OFF_LEVEL ##1 1'b1;
  endsequence
  a_input_quiet: assert property ((PIN_OUT & ~PIN_OE) == '0)
    else $error("input pin driven high");
  a_reset_idle: assert property ($fell(RST) |-> PIN_OE == '0 && PIN_OUT == '0)
    else $error("pins not idle after reset");
  a_read_wait: assert property (rd_take |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_ready_cause: assert property (!HREADYOUT |-> $past(rd_take))
    else $error("wait state without read");
  a_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  a_pins_stable: assert property (!wr_d1 |=> $stable(PIN_OE) && $stable(PIN_OUT))
    else $error("pins moved without write");
  a_data_hold: assert property ($changed(HRDATA) |-> $past(rd_take, 2))
    else $error("read data moved without read");
  a_level_pins: assert property (lvl0_wr |=> PIN_OUT[31:0] == ($past(HWDATA) & PIN_OE[31:0]))
    else $error("level write not on pins");
endmodule // gpo_drive_asserts

bind gpo_output_drive gpo_drive_asserts i_chk (.MCLK(MCLK), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));

//--- test/gpo_pin_model.sv
`timescale 1ns/100ps
module gpo_pin_model (
  input  wire gpo_pkg::gpo_pins_t pin_out,
  input  wire gpo_pkg::gpo_pins_t pin_oe,
  output gpo_pkg::gpo_pins_t      pad
);
  import gpo_pkg::*;
  // released pads rise to the board pull-up
  assign pad = (pin_out & pin_oe) | ~pin_oe;
endmodule // gpo_pin_model

//--- test/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
  import gpo_pkg::*;
  logic       mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic [1:0] htrans = 2'h0;
  gpo_addr_t  haddr = '0, b;
  gpo_word_t  hwdata = '0, hrdata, q, m, p;
  gpo_pins_t  pin_out, pin_oe, pad;
  int         bad_count = 0, total_checks = 0;
  always #12.5 mclk = ~mclk;
  gpo_output_drive i_dut (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  gpo_pin_model i_board (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));
  // hold until ready is seen high at a rising edge
  task automatic wait_rdy();
    logic r;
    do begin
      @(negedge mclk);
      r = hrdy;
      q = hrdata;
      @(posedge mclk);
    end while (r !== 1'b1);
  endtask
  // single word transfer: address phase, then data phase
  task automatic xfer(input gpo_addr_t a, input logic w, input gpo_word_t d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    #1;
  endtask
  task automatic rd_chk(input gpo_addr_t a, input gpo_word_t e);
    xfer(a, 1'b0, '0);
    `CHK("read", e, q)
    `CHK("resp", 1'b0, hresp)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hung bus
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    `CHK("oe", '0, pin_oe)
    // every group: level, set and clear views read 0 after reset, then one level word seen through those three views
    for (int g = 0; g < 5; g++) begin
      b = 32'(GPO_GROUP_BASE + GPO_GROUP_STRIDE * 12'(g));
      m = (g == 4) ? GPO_MASK_SINGLE : GPO_MASK_PAIR;
      p = 32'hA5C35A3C ^ 32'(g);
      for (int v = 1; v < 4; v++) rd_chk(b + 32'(4 * v), '0);
      xfer(b + 32'h4, 1'b1, p);
      for (int v = 1; v < 4; v++) rd_chk(b + 32'(4 * v), p & m);
    end
    `CHK("pad", '1, pad)
    $display("views test done");
    xfer(32'h10, 1'b1, 32'hFFFF0000);
    `CHK("oe", 32'h0000FFFF, pin_oe[31:0])
    `CHK("out", 32'h00005A3C, pin_out[31:0])
    xfer(32'h18, 1'b1, 32'h00FF00C3);
    `CHK("pad", 32'hFFFF5AFF, pad[31:0])
    rd_chk(32'h1C, 32'hA5FF5AFF);
    xfer(32'h1C, 1'b1, 32'hF00F000F);
    `CHK("out", 32'h00005AF0, pin_out[31:0])
    rd_chk(32'h18, 32'h05F05AF0);
    xfer(32'h18, 1'b1, 32'h00000001);
    xfer(32'h1C, 1'b1, 32'h00000001);
    rd_chk(32'h14, 32'h05F05AF0);
    $display("set and clear test done");
    xfer(32'hB0, 1'b1, 32'h00000000);
    `CHK("out8", 16'h5A38, pin_out[143:128])
    rd_chk(32'h0, '0);
    $display("single bank test done");
    tally_and_finish();
  end
endmodule // tb
